// ---- rtl/rail_ctrl_pkg.sv ----
// Purpose: shared constants and types for the rail set-point block
// Assumes: 50 MHz reference clock, 8-bit register port
// Notes: timing figures are kept in ns, cycle counts derive from them
`default_nettype none

package rail_ctrl_pkg;

  localparam int CLK_PERIOD_NS = 20;
  localparam int NUM_RAILS = 2;
  localparam int CODE_W = 6;
  localparam int MV_W = 12;

  // register offsets
  localparam logic [7:0] RAMP_CTRL_OFS = 8'h1a;
  localparam logic [7:0] AUX_VOLT_OFS = 8'h1b;

  // reset values
  localparam logic [7:0] RAMP_CTRL_RESET = 8'h06;
  localparam logic [7:0] AUX_VOLT_RESET = 8'h1f;

  // field positions
  localparam int TRIGGER_BIT = 7;
  localparam int AUTO_APPLY_BIT = 6;
  localparam int RATE_LSB = 0;
  localparam int RATE_W = 3;
  localparam int AUX_CODE_LSB = 0;
  localparam logic [2:0] RATE_IMMEDIATE = 3'h7;

  // dwell per step, ns
  localparam int DWELL0_NS = 160000;
  localparam int DWELL1_NS = 80000;
  localparam int DWELL2_NS = 40000;
  localparam int DWELL3_NS = 20000;
  localparam int DWELL4_NS = 10000;
  localparam int DWELL5_NS = 5000;
  localparam int DWELL6_NS = 2500;
  localparam int DWELL0_CYC = (DWELL0_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DWELL1_CYC = (DWELL1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DWELL2_CYC = (DWELL2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DWELL3_CYC = (DWELL3_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DWELL4_CYC = (DWELL4_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DWELL5_CYC = (DWELL5_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DWELL6_CYC = (DWELL6_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DWELL_W = 16;

  // monitor blanking after an aux regulator write
  localparam int BLANK_NS = 5000000;
  localparam int BLANK_CYC = (BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BLANK_W = 18;

  // aux regulator code to millivolts
  localparam logic [CODE_W-1:0] AUX_FINE_LAST = 6'h19;
  localparam logic [CODE_W-1:0] AUX_COARSE_FIRST = 6'h1a;
  localparam logic [MV_W-1:0] AUX_FINE_BASE_MV = 12'h384;
  localparam logic [MV_W-1:0] AUX_FINE_STEP_MV = 12'h019;
  localparam logic [MV_W-1:0] AUX_COARSE_BASE_MV = 12'h60e;
  localparam logic [MV_W-1:0] AUX_COARSE_STEP_MV = 12'h032;

  typedef enum logic [1:0] {
    RAMP_IDLE = 2'b01,
    RAMP_MOVE = 2'b10
  } ramp_state_type;

  typedef struct packed {
    logic write;
    logic read;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_type;

endpackage : rail_ctrl_pkg

`default_nettype wire

// ---- rtl/rail_stepper.sv ----
// Purpose: one buck rail's internal set-point, moved one code per step
// Assumes: step and jump never both high
// Notes: target is captured on load, setpoint chases it
`default_nettype none

module rail_stepper #(
  parameter logic [rail_ctrl_pkg::CODE_W-1:0] RESET_CODE = 6'h00
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic load,
  input wire logic [rail_ctrl_pkg::CODE_W-1:0] target_in,
  input wire logic step,
  input wire logic jump,
  output logic [rail_ctrl_pkg::CODE_W-1:0] setpoint_reg,
  output logic [rail_ctrl_pkg::CODE_W-1:0] target_reg,
  output logic at_target
);

  logic [rail_ctrl_pkg::CODE_W-1:0] setpoint_next;
  logic [rail_ctrl_pkg::CODE_W-1:0] target_next;

  assign at_target = (setpoint_reg == target_reg);

  always_comb begin
    target_next = load ? target_in : target_reg;
    setpoint_next = setpoint_reg;
    if (jump) begin
      setpoint_next = target_reg;
    end else if (step && !at_target) begin
      if (setpoint_reg < target_reg) begin
        setpoint_next = setpoint_reg + 6'h01;
      end else begin
        setpoint_next = setpoint_reg - 6'h01;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      setpoint_reg <= RESET_CODE;
      target_reg <= RESET_CODE;
    end else begin
      setpoint_reg <= setpoint_next;
      target_reg <= target_next;
    end
  end

endmodule : rail_stepper

`default_nettype wire

// ---- rtl/rail_setpoint_regs.sv ----
// Purpose: ramp control and aux regulator voltage registers
// Assumes: register port requests are one-cycle pulses on ref_clk
// Notes: buck set-point registers live outside, updates arrive as pulses
//
// How it works
// - only the two buck rails are ramped
// - trigger write of one starts both rails
// - trigger clears itself when the transition ends
// - auto apply starts ramp on set-point update
// - rate code picks dwell per step
// - rate code seven jumps at once
// - ramp control at 0x1A, resets 0x6
// - aux voltage at 0x1B, resets 0x1F
// - aux code maps to millivolts, two slopes
// - any aux write blanks monitors 5 ms
// - aux write needs password unlock
`default_nettype none

module rail_setpoint_regs #(
  parameter int DWELL0_CYCLES = rail_ctrl_pkg::DWELL0_CYC,
  parameter int BLANK_CYCLES = rail_ctrl_pkg::BLANK_CYC,
  parameter logic [rail_ctrl_pkg::CODE_W-1:0] BUCK_RESET_CODE = 6'h00
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire rail_ctrl_pkg::reg_req_type reg_req,
  output logic [7:0] reg_rdata_reg,
  input wire logic unlock_ok,
  input wire logic [rail_ctrl_pkg::NUM_RAILS-1:0] rail_update,
  input wire logic [rail_ctrl_pkg::NUM_RAILS*rail_ctrl_pkg::CODE_W-1:0]
    rail_target,
  output logic [rail_ctrl_pkg::NUM_RAILS*rail_ctrl_pkg::CODE_W-1:0]
    rail_setpoint,
  output logic ramp_busy,
  output logic [rail_ctrl_pkg::CODE_W-1:0] aux_code_reg,
  output logic [rail_ctrl_pkg::MV_W-1:0] aux_mv_reg,
  output logic monitor_blank
);

  localparam int NR = rail_ctrl_pkg::NUM_RAILS;
  localparam int CW = rail_ctrl_pkg::CODE_W;

  rail_ctrl_pkg::ramp_state_type state_reg, state_next;
  logic trigger_reg, trigger_next;
  logic auto_reg, auto_next;
  logic [rail_ctrl_pkg::RATE_W-1:0] rate_reg, rate_next;
  logic [rail_ctrl_pkg::DWELL_W-1:0] dwell_reg, dwell_next;
  logic [rail_ctrl_pkg::DWELL_W-1:0] dwell_limit;
  logic [rail_ctrl_pkg::BLANK_W-1:0] blank_reg, blank_next;
  logic [CW-1:0] aux_code_next;
  logic [rail_ctrl_pkg::MV_W-1:0] aux_mv_next;
  logic [7:0] reg_rdata_next;
  logic ramp_wr, aux_wr, go_start, auto_start, start, tick, jump, all_at;
  logic [NR-1:0] at_target;
  logic [NR*CW-1:0] rail_goal;

  assign ramp_wr = reg_req.write
    && (reg_req.addr == rail_ctrl_pkg::RAMP_CTRL_OFS);
  assign aux_wr = reg_req.write
    && (reg_req.addr == rail_ctrl_pkg::AUX_VOLT_OFS);
  assign go_start = ramp_wr
    && reg_req.wdata[rail_ctrl_pkg::TRIGGER_BIT];
  assign auto_start = auto_reg && (|rail_update);
  assign start = go_start || auto_start;
  assign ramp_busy = (state_reg == rail_ctrl_pkg::RAMP_MOVE);
  assign all_at = &at_target;
  assign jump = ramp_busy && (rate_reg == rail_ctrl_pkg::RATE_IMMEDIATE);
  assign tick = ramp_busy && !jump && (dwell_reg == dwell_limit - 16'h0001);
  assign monitor_blank = (blank_reg != '0);

  // dwell length per rate code
  always_comb begin
    case (rate_reg)
      3'h0: dwell_limit = rail_ctrl_pkg::DWELL_W'(DWELL0_CYCLES);
      3'h1: dwell_limit = rail_ctrl_pkg::DWELL_W'(rail_ctrl_pkg::DWELL1_CYC);
      3'h2: dwell_limit = rail_ctrl_pkg::DWELL_W'(rail_ctrl_pkg::DWELL2_CYC);
      3'h3: dwell_limit = rail_ctrl_pkg::DWELL_W'(rail_ctrl_pkg::DWELL3_CYC);
      3'h4: dwell_limit = rail_ctrl_pkg::DWELL_W'(rail_ctrl_pkg::DWELL4_CYC);
      3'h5: dwell_limit = rail_ctrl_pkg::DWELL_W'(rail_ctrl_pkg::DWELL5_CYC);
      3'h6: dwell_limit = rail_ctrl_pkg::DWELL_W'(rail_ctrl_pkg::DWELL6_CYC);
      default: dwell_limit = 16'h0001;
    endcase
  end

  // ramp sequencing and ramp control register
  always_comb begin
    state_next = state_reg;
    trigger_next = trigger_reg;
    auto_next = auto_reg;
    rate_next = rate_reg;
    dwell_next = dwell_reg;
    case (state_reg)
      rail_ctrl_pkg::RAMP_IDLE: begin
        if (start) begin
          state_next = rail_ctrl_pkg::RAMP_MOVE;
        end
      end
      rail_ctrl_pkg::RAMP_MOVE: begin
        if (!start && all_at) begin
          state_next = rail_ctrl_pkg::RAMP_IDLE;
        end
      end
      default: state_next = rail_ctrl_pkg::RAMP_IDLE;
    endcase
    if (go_start) begin
      trigger_next = 1'b1;
    end else if (ramp_busy && all_at && !start) begin
      trigger_next = 1'b0;
    end
    if (ramp_wr) begin
      auto_next = reg_req.wdata[rail_ctrl_pkg::AUTO_APPLY_BIT];
      rate_next = reg_req.wdata[rail_ctrl_pkg::RATE_LSB +: 3];
    end
    if (start || !ramp_busy || tick) begin
      dwell_next = '0;
    end else begin
      dwell_next = dwell_reg + 16'h0001;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_reg <= rail_ctrl_pkg::RAMP_IDLE;
      trigger_reg <=
        rail_ctrl_pkg::RAMP_CTRL_RESET[rail_ctrl_pkg::TRIGGER_BIT];
      auto_reg <=
        rail_ctrl_pkg::RAMP_CTRL_RESET[rail_ctrl_pkg::AUTO_APPLY_BIT];
      rate_reg <= rail_ctrl_pkg::RAMP_CTRL_RESET[2:0];
      dwell_reg <= '0;
    end else begin
      state_reg <= state_next;
      trigger_reg <= trigger_next;
      auto_reg <= auto_next;
      rate_reg <= rate_next;
      dwell_reg <= dwell_next;
    end
  end

  // only the two buck rails get steppers
  genvar gi;
  generate
    for (gi = 0; gi < NR; gi++) begin : g_rail
      rail_stepper #(
        .RESET_CODE(BUCK_RESET_CODE)
      ) u_step (
        .ref_clk(ref_clk),
        .rst(rst),
        .load(start),
        .target_in(rail_target[gi*CW +: CW]),
        .step(tick),
        .jump(jump),
        .setpoint_reg(rail_setpoint[gi*CW +: CW]),
        .target_reg(rail_goal[gi*CW +: CW]),
        .at_target(at_target[gi])
      );
    end
  endgenerate

  // aux regulator register, blanking and voltage readout
  always_comb begin
    aux_code_next = aux_code_reg;
    if (aux_wr && unlock_ok) begin
      aux_code_next = reg_req.wdata[rail_ctrl_pkg::AUX_CODE_LSB +: 6];
    end
    if (aux_wr) begin
      blank_next = rail_ctrl_pkg::BLANK_W'(BLANK_CYCLES);
    end else if (blank_reg != '0) begin
      blank_next = blank_reg - 18'h00001;
    end else begin
      blank_next = '0;
    end
    if (aux_code_reg <= rail_ctrl_pkg::AUX_FINE_LAST) begin
      aux_mv_next = rail_ctrl_pkg::AUX_FINE_BASE_MV
        + MV_MUL(rail_ctrl_pkg::AUX_FINE_STEP_MV, aux_code_reg);
    end else begin
      aux_mv_next = rail_ctrl_pkg::AUX_COARSE_BASE_MV
        + MV_MUL(rail_ctrl_pkg::AUX_COARSE_STEP_MV,
                 aux_code_reg - rail_ctrl_pkg::AUX_COARSE_FIRST);
    end
  end

  function automatic logic [rail_ctrl_pkg::MV_W-1:0] MV_MUL(
    input logic [rail_ctrl_pkg::MV_W-1:0] step_mv,
    input logic [CW-1:0] n
  );
    logic [rail_ctrl_pkg::MV_W-1:0] wide_n;
    wide_n = {6'h00, n};
    return rail_ctrl_pkg::MV_W'(step_mv * wide_n);
  endfunction : MV_MUL

  // read path, reserved bits zero, unmapped reads zero
  always_comb begin
    reg_rdata_next = reg_rdata_reg;
    if (reg_req.read) begin
      case (reg_req.addr)
        rail_ctrl_pkg::RAMP_CTRL_OFS: reg_rdata_next =
          {trigger_reg, auto_reg, 3'h0, rate_reg};
        rail_ctrl_pkg::AUX_VOLT_OFS: reg_rdata_next =
          {2'h0, aux_code_reg};
        default: reg_rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      aux_code_reg <= rail_ctrl_pkg::AUX_VOLT_RESET[5:0];
      aux_mv_reg <= '0;
      blank_reg <= '0;
      reg_rdata_reg <= 8'h00;
    end else begin
      aux_code_reg <= aux_code_next;
      aux_mv_reg <= aux_mv_next;
      blank_reg <= blank_next;
      reg_rdata_reg <= reg_rdata_next;
    end
  end

  // checks
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  sequence s_go_write;
    ramp_wr && reg_req.wdata[rail_ctrl_pkg::TRIGGER_BIT];
  endsequence

  sequence s_move_done;
    ramp_busy && all_at && !start;
  endsequence

  chk_go_starts: assert property (
    s_go_write |=> trigger_reg && ramp_busy)
    else $error("trigger write did not start a ramp");

  chk_zero_write_idle: assert property (
    ramp_wr && !reg_req.wdata[rail_ctrl_pkg::TRIGGER_BIT] && !ramp_busy
    && !auto_start |=> !ramp_busy && !trigger_reg)
    else $error("zero trigger write changed state");

  chk_trigger_clear: assert property (
    s_move_done |=> !trigger_reg && !ramp_busy)
    else $error("trigger not cleared at end of transition");

  chk_trigger_holds: assert property (
    trigger_reg && !all_at |=> trigger_reg)
    else $error("trigger cleared before transition ended");

  chk_auto_start: assert property (
    auto_reg && (|rail_update) |=> ramp_busy)
    else $error("auto apply did not start ramp");

  chk_no_auto_start: assert property (
    !auto_reg && !ramp_busy && !go_start |=> !ramp_busy)
    else $error("ramp started without trigger");

  chk_idle_still: assert property (
    !ramp_busy && !start |=> $stable(rail_setpoint))
    else $error("set-point moved while idle");

  chk_dwell_gap: assert property (
    tick && rate_reg == 3'h6 && !start |=> (!tick)[*8])
    else $error("dwell too short");

  chk_jump_now: assert property (
    jump && !start |=> rail_setpoint == rail_goal)
    else $error("immediate code did not jump");

  chk_jump_ends: assert property (
    jump && !start ##1 !start |=> !ramp_busy)
    else $error("immediate transition did not end");

  chk_step_one: assert property (
    tick && !at_target[0] |=>
    (rail_setpoint[CW-1:0] == $past(rail_setpoint[CW-1:0]) + 6'h01) ||
    (rail_setpoint[CW-1:0] == $past(rail_setpoint[CW-1:0]) - 6'h01))
    else $error("set-point did not move one code");

  chk_aux_locked: assert property (
    aux_wr && !unlock_ok |=> $stable(aux_code_reg))
    else $error("locked aux write took effect");

  chk_aux_takes: assert property (
    aux_wr && unlock_ok |=> aux_code_reg == $past(reg_req.wdata[CW-1:0]))
    else $error("unlocked aux write not taken");

  chk_blank_hold: assert property (
    aux_wr |=> monitor_blank[*8])
    else $error("monitor blanking missing after aux write");

  chk_blank_load: assert property (
    aux_wr |=> blank_reg == rail_ctrl_pkg::BLANK_W'(BLANK_CYCLES))
    else $error("blanking interval not loaded");

  chk_blank_count: assert property (
    !aux_wr && monitor_blank |=> blank_reg == $past(blank_reg) - 18'h00001)
    else $error("blanking interval not counting down");

  chk_reserved_zero: assert property (
    reg_req.read |=>
    ($past(reg_req.addr) != rail_ctrl_pkg::RAMP_CTRL_OFS
      || reg_rdata_reg[5:3] == 3'h0)
    && ($past(reg_req.addr) != rail_ctrl_pkg::AUX_VOLT_OFS
      || reg_rdata_reg[7:6] == 2'h0))
    else $error("reserved bits read nonzero");

  chk_aux_mv: assert property (
    aux_code_reg == 6'h1f && $stable(aux_code_reg) |=> aux_mv_reg == 12'h708)
    else $error("aux millivolt mapping wrong");

endmodule : rail_setpoint_regs

`default_nettype wire

// ---- testbench/rail_setpoint_regs_tb_top.sv ----
// Purpose: self-checking bench for the rail set-point register block
// Assumes: dwell code 0 and blanking shortened through parameters
// Notes: inputs change on the falling edge of ref_clk
`default_nettype none
`define CHK(nm, ex, gt) begin cmp_count++; if ((ex) !== (gt)) begin \
  fails++; $display("BAD %s expected %h seen %h", nm, ex, gt); end end

module rail_setpoint_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int DW0 = 20;
  localparam int BLK = 40;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  rail_ctrl_pkg::reg_req_type reg_req;
  logic [7:0] rdata;
  logic unlock_ok;
  logic [1:0] rail_update;
  logic [11:0] rail_target;
  logic [11:0] rail_setpoint;
  logic ramp_busy;
  logic [5:0] aux_code;
  logic [11:0] aux_mv;
  logic monitor_blank;
  int fails = 0;
  int cmp_count = 0;
  logic [5:0] cur [2];
  logic [5:0] aux_exp;
  logic [7:0] rd;

  always #10 ref_clk = ~ref_clk;

  rail_setpoint_regs #(.DWELL0_CYCLES(DW0), .BLANK_CYCLES(BLK)) dut (
    .ref_clk(ref_clk), .rst(rst), .reg_req(reg_req), .reg_rdata_reg(rdata),
    .unlock_ok(unlock_ok), .rail_update(rail_update),
    .rail_target(rail_target), .rail_setpoint(rail_setpoint),
    .ramp_busy(ramp_busy), .aux_code_reg(aux_code), .aux_mv_reg(aux_mv),
    .monitor_blank(monitor_blank)
  );

  task automatic finish_test;
    if (fails == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : finish_test

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    reg_req.write = 1'b1;
    reg_req.addr = a;
    reg_req.wdata = d;
    @(negedge ref_clk);
    reg_req.write = 1'b0;
  endtask : wr

  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(negedge ref_clk);
    reg_req.read = 1'b1;
    reg_req.addr = a;
    @(negedge ref_clk);
    reg_req.read = 1'b0;
    d = rdata;
  endtask : rd_reg

  function automatic int dwell(input logic [2:0] r);
    case (r)
      3'h0: return DW0;
      3'h1: return rail_ctrl_pkg::DWELL1_CYC;
      3'h2: return rail_ctrl_pkg::DWELL2_CYC;
      3'h3: return rail_ctrl_pkg::DWELL3_CYC;
      3'h4: return rail_ctrl_pkg::DWELL4_CYC;
      3'h5: return rail_ctrl_pkg::DWELL5_CYC;
      3'h6: return rail_ctrl_pkg::DWELL6_CYC;
      default: return 0;
    endcase
  endfunction : dwell

  function automatic logic [11:0] mv_of(input logic [5:0] c);
    if (c <= 6'h19) return 12'(900 + 25 * int'(c));
    return 12'(1550 + 50 * (int'(c) - 26));
  endfunction : mv_of

  // one transition of both buck rails, by trigger or by auto apply
  task automatic ramp(input logic [2:0] r, input bit auto_start);
    int n;
    int v;
    int maxd;
    int ex;
    logic [5:0] t [2];
    logic [5:0] prev [2];
    logic [5:0] s;
    maxd = 0;
    for (int i = 0; i < 2; i++) begin
      v = int'(cur[i]) + int'($urandom_range(6)) - 3;
      if (v < 0) v = 0;
      if (v > 63) v = 63;
      if (v == int'(cur[i])) v = (v == 63) ? 62 : v + 1;
      t[i] = 6'(v);
      v = (v > int'(cur[i])) ? v - int'(cur[i]) : int'(cur[i]) - v;
      if (v > maxd) maxd = v;
    end
    if (auto_start) wr(rail_ctrl_pkg::RAMP_CTRL_OFS, {2'b01, 3'h0, r});
    @(negedge ref_clk);
    rail_target = {t[1], t[0]};
    if (auto_start) begin
      @(negedge ref_clk);
      rail_update = 2'b11;
      @(negedge ref_clk);
      rail_update = 2'b00;
    end else begin
      wr(rail_ctrl_pkg::RAMP_CTRL_OFS, {2'b10, 3'h0, r});
    end
    `CHK("busy at start", 1'b1, ramp_busy)
    prev = cur;
    n = 0;
    while (ramp_busy === 1'b1 && n < 20000) begin
      @(negedge ref_clk);
      n++;
      for (int i = 0; i < 2; i++) begin
        s = rail_setpoint[6*i +: 6];
        if (r != 3'h7)
          `CHK("step size", 1'b1, (s == prev[i] || s == prev[i] + 6'h01 ||
            s == prev[i] - 6'h01))
        prev[i] = s;
      end
    end
    if (n >= 20000) begin
      fails++;
      finish_test();
    end
    ex = maxd * dwell(r);
    `CHK("ramp length", 1'b1, (n >= ex - 2 && n <= ex + 4))
    `CHK("setpoint", {t[1], t[0]}, rail_setpoint)
    `CHK("aux untouched", aux_exp, aux_code)
    rd_reg(rail_ctrl_pkg::RAMP_CTRL_OFS, rd);
    `CHK("ramp ctrl after", {1'b0, auto_start, 3'h0, r}, rd)
    cur = t;
  endtask : ramp

  // aux regulator write, then code, millivolts, blanking, readback
  task automatic aux_wr(input logic [7:0] d, input logic unl);
    int n;
    @(negedge ref_clk);
    unlock_ok = unl;
    wr(rail_ctrl_pkg::AUX_VOLT_OFS, d);
    if (unl) aux_exp = d[5:0];
    `CHK("aux code", aux_exp, aux_code)
    @(negedge ref_clk);
    `CHK("aux mv", mv_of(aux_exp), aux_mv)
    n = 0;
    while (monitor_blank === 1'b1 && n < 100) begin
      @(negedge ref_clk);
      n++;
    end
    if (n >= 100) begin
      fails++;
      finish_test();
    end
    `CHK("blank length", 1'b1, (n >= BLK - 3 && n <= BLK + 1))
    rd_reg(rail_ctrl_pkg::AUX_VOLT_OFS, rd);
    `CHK("aux readback", {2'b00, aux_exp}, rd)
  endtask : aux_wr

  initial begin
    repeat (100000) @(posedge ref_clk);
    fails++;
    finish_test();
  end

  initial begin
    reg_req = '0;
    unlock_ok = 1'b0;
    rail_update = 2'b00;
    rail_target = 12'h000;
    aux_exp = 6'h1f;
    cur[0] = 6'h00;
    cur[1] = 6'h00;
    void'($urandom(32'h0e8522a4));
    repeat (10) @(negedge ref_clk);
    rst = 1'b0;
    `CHK("busy idle", 1'b0, ramp_busy)
    `CHK("blank idle", 1'b0, monitor_blank)
    rd_reg(rail_ctrl_pkg::RAMP_CTRL_OFS, rd);
    `CHK("ramp ctrl reset", 8'h06, rd)
    rd_reg(rail_ctrl_pkg::AUX_VOLT_OFS, rd);
    `CHK("aux reset", 8'h1f, rd)
    `CHK("aux mv reset", 12'h708, aux_mv)
    rd_reg(8'h1c, rd);
    `CHK("unmapped read", 8'h00, rd)
    rail_target = 12'(($urandom_range(63) << 6) | 1);
    wr(rail_ctrl_pkg::RAMP_CTRL_OFS, 8'h3e);
    repeat (3) @(negedge ref_clk);
    `CHK("trigger zero idle", 1'b0, ramp_busy)
    rd_reg(rail_ctrl_pkg::RAMP_CTRL_OFS, rd);
    `CHK("reserved ignored", 8'h06, rd)
    rail_update = 2'b11;
    @(negedge ref_clk);
    rail_update = 2'b00;
    repeat (3) @(negedge ref_clk);
    `CHK("no auto start", 1'b0, ramp_busy)
    `CHK("setpoint held", 12'h000, rail_setpoint)
    for (int r = 0; r < 8; r++) ramp(3'(r), 1'b0);
    ramp(3'h5, 1'b1);
    ramp(3'h7, 1'b1);
    repeat (4) ramp(3'($urandom_range(7)), 1'($urandom_range(1)));
    aux_wr(8'hc0, 1'b1);
    aux_wr(8'h19, 1'b1);
    aux_wr(8'h1a, 1'b1);
    aux_wr(8'hff, 1'b1);
    aux_wr(8'($urandom), 1'b0);
    repeat (3) aux_wr(8'($urandom), 1'($urandom_range(1)));
    finish_test();
  end
endmodule : rail_setpoint_regs_tb_top

`default_nettype wire
